/* File: verilog/rxmon_params.svh */
// rxmon_params.svh: offsets, field positions, reset values and timing counts
`ifndef RXMON_PARAMS_SVH
`define RXMON_PARAMS_SVH

// byte offsets of the monitor map
`define RXMON_OFS_ALARM      7'h1A
`define RXMON_OFS_TEMP_INT   7'h1C
`define RXMON_OFS_TEMP_FRAC  7'h1D
`define RXMON_OFS_V33_MSB    7'h20
`define RXMON_OFS_V25_MSB    7'h22
`define RXMON_OFS_RSV_FIRST  7'h24
`define RXMON_OFS_RSV_LAST   7'h3F
`define RXMON_OFS_PWR_FIRST  7'h40
`define RXMON_OFS_PWR_LAST   7'h57
// own registers: interrupt status and mask
`define RXMON_OFS_IRQ_STAT   7'h78
`define RXMON_OFS_IRQ_MASK   7'h79

// alarm byte field positions
`define RXMON_BIT_LO_CH3     6
`define RXMON_BIT_HI_CH2     3
`define RXMON_BIT_LO_CH2     2

// interrupt status bit positions
`define RXMON_IRQ_ALARM      0
`define RXMON_IRQ_SAMPLE     1

// reset values
`define RXMON_RST_BYTE       8'h00
`define RXMON_RST_MASK       8'h00

// measurement sample interval
`define RXMON_SAMPLE_NS      1000
`define RXMON_CLK_MHZ        200

`endif

/* File: verilog/rxmon_pkg.sv */
// rxmon_pkg.sv: types shared by the monitor register bank
package rxmon_pkg;
   typedef logic [6:0] rxmon_addr_t;
   typedef logic [7:0] rxmon_byte_t;
   typedef logic [15:0] rxmon_word_t;
endpackage

/* File: verilog/rxmon_pwr_mem.sv */
// rxmon_pwr_mem.sv: per-channel power word store with registered read
`timescale 1ns/1ps
module rxmon_pwr_mem #(
   parameter int N_WORDS = 12,
   parameter int AW      = 4
) (
   // clock and reset
   input  wire logic          clock_i,
   input  wire logic          resetn_i,
   // write port
   input  wire logic          wr_en_i,
   input  wire logic [AW-1:0] wr_addr_i,
   input  wire logic [15:0]   wr_data_i,
   // read port
   input  wire logic [AW-1:0] rd_addr_i,
   output logic [15:0]        rd_data_o
);
   logic [15:0] mem_r [N_WORDS];

   // word storage, cleared at reset
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < N_WORDS; i++) begin
            mem_r[i] <= 16'h0000;
         end
      end else if (wr_en_i && (int'(wr_addr_i) < N_WORDS)) begin
         mem_r[wr_addr_i] <= wr_data_i;
      end
   end

   // registered read
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rd_data_o <= 16'h0000;
      end else if (int'(rd_addr_i) < N_WORDS) begin
         rd_data_o <= mem_r[rd_addr_i];
      end else begin
         rd_data_o <= 16'h0000;
      end
   end
endmodule // rxmon_pwr_mem

/* File: verilog/rxmon_bank.sv */
// rxmon_bank.sv: receiver monitor and alarm register bank
`timescale 1ns/1ps
`include "rxmon_params.svh"

// Operation
// - power alarms latch, clear when host reads
// - byte 26 bit 6: ch3 low alarm
// - byte 26 bit 3: ch2 high alarm
// - byte 26 bit 2: ch2 low alarm
// - temperature high byte: signed integer part
// - temperature low byte: 1/256 degree fraction
// - supply words: 16 bit, 100 uV, MSB first
// - 3.3 V monitor at bytes 32-33
// - 2.5 V monitor at bytes 34-35
// - power words: 16 bit, 0.1 uW, MSB first
// - ch11 at 64, ch10 at 66, downward
// - bytes 36 to 63 read zero
module rxmon_bank #(
   parameter int N_CH = 12
) (
   // clock and reset
   input  wire logic                 clock_i,
   input  wire logic                 resetn_i,
   // host register port
   input  wire rxmon_pkg::rxmon_addr_t addr_i,
   input  wire rxmon_pkg::rxmon_byte_t wdata_i,
   input  wire logic                 wr_i,
   input  wire logic                 rd_i,
   output rxmon_pkg::rxmon_byte_t    rdata_o,
   // alarm conditions from the analog front end (asynchronous)
   input  wire logic                 lo_alarm_ch3_i,
   input  wire logic                 hi_alarm_ch2_i,
   input  wire logic                 lo_alarm_ch2_i,
   // measurements from the front end, same clock
   input  wire logic [15:0]          temp_i,
   input  wire logic [15:0]          v33_i,
   input  wire logic [15:0]          v25_i,
   input  wire logic                 pwr_vld_i,
   input  wire logic [3:0]           pwr_ch_i,
   input  wire logic [15:0]          pwr_i,
   // interrupt
   output logic                      irq_o
);
   import rxmon_pkg::*;

   localparam int SAMPLE_CYC =
      (`RXMON_SAMPLE_NS * `RXMON_CLK_MHZ) / 1000;

   // =========================================================
   // helpers
   // =========================================================
   // byte offset to power channel index, ch11 at the first slot
   function automatic logic [3:0] pwr_chan(input rxmon_addr_t a);
      logic [6:0] slot;
      slot = (a - `RXMON_OFS_PWR_FIRST) >> 1;
      pwr_chan = 4'(N_CH - 1) - slot[3:0];
   endfunction

   function automatic logic in_pwr(input rxmon_addr_t a);
      in_pwr = (a >= `RXMON_OFS_PWR_FIRST) && (a <= `RXMON_OFS_PWR_LAST);
   endfunction

   // =========================================================
   // input synchronisers
   // =========================================================
   logic [2:0] alm_meta_r;
   logic [2:0] alm_sync_r;

   // two flops for the asynchronous alarm levels
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         alm_meta_r <= 3'h0;
         alm_sync_r <= 3'h0;
      end else begin
         alm_meta_r <= {lo_alarm_ch3_i, hi_alarm_ch2_i, lo_alarm_ch2_i};
         alm_sync_r <= alm_meta_r;
      end
   end

   // =========================================================
   // sample divider
   // =========================================================
   logic [15:0] div_r;
   logic        tick_r;

   // enable pulse once per sample interval
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         div_r  <= 16'h0000;
         tick_r <= 1'b0;
      end else if (div_r == 16'(SAMPLE_CYC - 1)) begin
         div_r  <= 16'h0000;
         tick_r <= 1'b1;
      end else begin
         div_r  <= div_r + 16'h0001;
         tick_r <= 1'b0;
      end
   end

   // =========================================================
   // measurement snapshots
   // =========================================================
   logic [15:0] temp_r;
   logic [15:0] v33_r;
   logic [15:0] v25_r;

   // capture analog readings on each sample tick
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         temp_r <= 16'h0000;
         v33_r  <= 16'h0000;
         v25_r  <= 16'h0000;
      end else if (tick_r) begin
         temp_r <= temp_i;
         v33_r  <= v33_i;
         v25_r  <= v25_i;
      end
   end

   // =========================================================
   // alarm latch (clear on read)
   // =========================================================
   logic [7:0] alarm_r;
   logic [7:0] alarm_set;
   logic       rd_alarm;

   assign rd_alarm = rd_i && (addr_i == `RXMON_OFS_ALARM);

   // map conditions onto their bits, reserved bits stay zero
   always_comb begin
      alarm_set = 8'h00;
      alarm_set[`RXMON_BIT_LO_CH3] = alm_sync_r[2];
      alarm_set[`RXMON_BIT_HI_CH2] = alm_sync_r[1];
      alarm_set[`RXMON_BIT_LO_CH2] = alm_sync_r[0];
   end

   // sticky bits, a new event beats the read clear
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         alarm_r <= `RXMON_RST_BYTE;
      end else if (rd_alarm) begin
         alarm_r <= alarm_set;
      end else begin
         alarm_r <= alarm_r | alarm_set;
      end
   end

   // =========================================================
   // power word store
   // =========================================================
   logic [15:0] pwr_rd;
   logic        pwr_hi_r;

   rxmon_pwr_mem #(
      .N_WORDS (N_CH),
      .AW      (4)
   ) u_pwr_mem (
      .clock_i   (clock_i),
      .resetn_i  (resetn_i),
      .wr_en_i   (pwr_vld_i),
      .wr_addr_i (pwr_ch_i),
      .wr_data_i (pwr_i),
      .rd_addr_i (pwr_chan(addr_i)),
      .rd_data_o (pwr_rd)
   );

   // remember which half of a power word was addressed
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pwr_hi_r <= 1'b0;
      end else if (rd_i) begin
         pwr_hi_r <= ~addr_i[0];
      end
   end

   // =========================================================
   // interrupt status and mask
   // =========================================================
   logic [7:0] irq_stat_r;
   logic [7:0] irq_mask_r;
   logic [7:0] irq_ev;
   logic [7:0] w1c;
   logic [7:0] alarm_prev_r;

   // previous alarm inputs for rise detection
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         alarm_prev_r <= 8'h00;
      end else begin
         alarm_prev_r <= alarm_set;
      end
   end

   // events: an alarm rises, or a sample was taken
   always_comb begin
      irq_ev = 8'h00;
      irq_ev[`RXMON_IRQ_ALARM]  = |(alarm_set & ~alarm_prev_r);
      irq_ev[`RXMON_IRQ_SAMPLE] = tick_r;
      w1c = 8'h00;
      if (wr_i && (addr_i == `RXMON_OFS_IRQ_STAT)) begin
         w1c = wdata_i;
      end
   end

   // sticky status, set wins over write-one-clear
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_stat_r <= `RXMON_RST_BYTE;
      end else begin
         irq_stat_r <= (irq_stat_r & ~w1c) | irq_ev;
      end
   end

   // mask register, the only fully writable location; status takes write-one-clear
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_mask_r <= `RXMON_RST_MASK;
      end else if (wr_i && (addr_i == `RXMON_OFS_IRQ_MASK)) begin
         irq_mask_r <= wdata_i;
      end
   end

   // level interrupt from a flop
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(((irq_stat_r & ~w1c) | irq_ev) & irq_mask_r);
      end
   end

   // =========================================================
   // read path
   // =========================================================
   logic       rd_d_r;
   logic       rd_pwr_r;
   logic [7:0] rd_byte_r;

   // decode non-memory bytes, everything else reads zero
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rd_byte_r <= 8'h00;
         rd_pwr_r  <= 1'b0;
         rd_d_r    <= 1'b0;
      end else begin
         rd_d_r   <= rd_i;
         rd_pwr_r <= rd_i && in_pwr(addr_i);
         if (rd_i) begin
            unique case (addr_i)
               `RXMON_OFS_ALARM:     rd_byte_r <= alarm_r;
               `RXMON_OFS_TEMP_INT:  rd_byte_r <= temp_r[15:8];
               `RXMON_OFS_TEMP_FRAC: rd_byte_r <= temp_r[7:0];
               `RXMON_OFS_V33_MSB:   rd_byte_r <= v33_r[15:8];
               7'h21:                rd_byte_r <= v33_r[7:0];
               `RXMON_OFS_V25_MSB:   rd_byte_r <= v25_r[15:8];
               7'h23:                rd_byte_r <= v25_r[7:0];
               `RXMON_OFS_IRQ_STAT:  rd_byte_r <= irq_stat_r;
               `RXMON_OFS_IRQ_MASK:  rd_byte_r <= irq_mask_r;
               default:              rd_byte_r <= 8'h00;
            endcase
         end
      end
   end

   // read data stands in the cycle after the strobe only
   always_comb begin
      if (!rd_d_r) begin
         rdata_o = 8'h00;
      end else if (rd_pwr_r) begin
         rdata_o = pwr_hi_r ? pwr_rd[15:8] : pwr_rd[7:0];
      end else begin
         rdata_o = rd_byte_r;
      end
   end
endmodule // rxmon_bank

/* File: sim/rxmon_bank_props.sv */
// rxmon_bank_props.sv: port-level assertions for the monitor register bank
`timescale 1ns/1ps
module rxmon_bank_props (
   // clock and reset
   input wire logic                   clock_i,
   input wire logic                   resetn_i,
   // host register port
   input wire rxmon_pkg::rxmon_addr_t addr_i,
   input wire logic                   rd_i,
   input wire rxmon_pkg::rxmon_byte_t rdata_o,
   // alarm conditions
   input wire logic                   lo_alarm_ch3_i,
   input wire logic                   hi_alarm_ch2_i,
   input wire logic                   lo_alarm_ch2_i
);
   import rxmon_pkg::*;
   // ==========
   // read data and alarm latch checks
   default clocking @(posedge clock_i); endclocking
   default disable iff (!resetn_i);

   idle_zero_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data not zero outside answer cycle");
   rsv_zero_a: assert property ($past(rd_i) && $past(addr_i) >= 7'h24
      && $past(addr_i) <= 7'h3F |-> rdata_o == 8'h00)
      else $error("reserved byte read not zero");
   gap_zero_a: assert property ($past(rd_i) && $past(addr_i) > 7'h57
      && $past(addr_i) < 7'h78 |-> rdata_o == 8'h00)
      else $error("unmapped byte read not zero");
   alarm_rsv_a: assert property ($past(rd_i) && $past(addr_i) == 7'h1A
      |-> (rdata_o & 8'hB3) == 8'h00)
      else $error("reserved alarm bits not zero");
   lo3_set_a: assert property (lo_alarm_ch3_i [*6] ##0
      (rd_i && addr_i == 7'h1A) |=> rdata_o[6])
      else $error("ch3 low alarm not seen");
   hi2_set_a: assert property (hi_alarm_ch2_i [*6] ##0
      (rd_i && addr_i == 7'h1A) |=> rdata_o[3])
      else $error("ch2 high alarm not seen");
   lo2_set_a: assert property (lo_alarm_ch2_i [*6] ##0
      (rd_i && addr_i == 7'h1A) |=> rdata_o[2])
      else $error("ch2 low alarm not seen");
   read_clear_a: assert property ((!lo_alarm_ch3_i) [*6] ##0
      (rd_i && addr_i == 7'h1A) ##2 (rd_i && addr_i == 7'h1A)
      |=> !rdata_o[6])
      else $error("alarm not cleared by read");
endmodule // rxmon_bank_props

bind rxmon_bank rxmon_bank_props i_rxmon_bank_props (.clock_i, .resetn_i,
   .addr_i, .rd_i, .rdata_o, .lo_alarm_ch3_i, .hi_alarm_ch2_i,
   .lo_alarm_ch2_i);

/* File: sim/rxmon_host.sv */
// rxmon_host.sv: management host model driving the register port
`timescale 1ns/1ps
module rxmon_host (
   // clock
   input  wire logic                   clock_i,
   // register port towards the bank
   output rxmon_pkg::rxmon_addr_t      addr_o,
   output rxmon_pkg::rxmon_byte_t      wdata_o,
   output logic                        wr_o,
   output logic                        rd_o,
   input  wire rxmon_pkg::rxmon_byte_t rdata_i
);
   import rxmon_pkg::*;
   // ==========
   // bus idle at time zero
   initial begin
      addr_o = 7'h00;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   // one-cycle write, then a quiet edge so strobes never double up
   task automatic wr8(input rxmon_addr_t a, input rxmon_byte_t d);
      wr_o <= 1'b1;
      addr_o <= a;
      wdata_o <= d;
      @(posedge clock_i);
      wr_o <= 1'b0;
      @(posedge clock_i);
   endtask
   // one-cycle read, data taken mid answer cycle where it has settled
   task automatic rd8(input rxmon_addr_t a, output rxmon_byte_t d);
      rd_o <= 1'b1;
      addr_o <= a;
      @(posedge clock_i);
      rd_o <= 1'b0;
      @(negedge clock_i);
      d = rdata_i;
      @(posedge clock_i);
   endtask
endmodule // rxmon_host

/* File: sim/tb.sv */
// tb.sv: self-checking bench for the monitor register bank
`timescale 1ns/1ps
module tb;
   import rxmon_pkg::*;
   logic        clock_i = 1'b0;
   logic        resetn_i = 1'b0;
   rxmon_addr_t addr;
   rxmon_byte_t wdata, rdata, d;
   logic        wr, rd, irq, vld = 1'b0;
   logic        lo3 = 1'b0, hi2 = 1'b0, lo2 = 1'b0;
   logic [3:0]  ch = 4'h0;
   logic [15:0] temp = 16'h0000, v33 = 16'h0000, v25 = 16'h0000;
   logic [15:0] pw = 16'h0000;
   int          failures = 0, checks = 0, i, k, alarm_m;
   int          pwr_m [12];
   rxmon_addr_t wa [4] = '{7'h1A, 7'h1C, 7'h2A, 7'h40};

   // ==========
   // clock, host model and bank
   always #2.5 clock_i = ~clock_i;
   rxmon_host i_rxmon_host (.clock_i, .addr_o(addr), .wdata_o(wdata),
      .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
   rxmon_bank i_rxmon_bank (.clock_i, .resetn_i, .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .lo_alarm_ch3_i(lo3), .hi_alarm_ch2_i(hi2), .lo_alarm_ch2_i(lo2),
      .temp_i(temp), .v33_i(v33), .v25_i(v25), .pwr_vld_i(vld),
      .pwr_ch_i(ch), .pwr_i(pw), .irq_o(irq));

   // expected byte at an address, msb of each word at the even byte
   function automatic logic [7:0] model(int a);
      logic [15:0] w;
      w = 16'h0000;
      if (a == 7'h1C || a == 7'h1D) w = temp;
      if (a == 7'h20 || a == 7'h21) w = v33;
      if (a == 7'h22 || a == 7'h23) w = v25;
      if (a >= 7'h40 && a <= 7'h57) w = 16'(pwr_m[11 - (a - 7'h40) / 2]);
      if (a == 7'h1A) w = 16'(alarm_m);
      return (a % 2 == 0 && a != 7'h1A) ? w[15:8] : w[7:0];
   endfunction
   // compare and count
   task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s exp %h seen %h", n, exp, seen);
      end
   endtask
   task automatic rdchk(logic [6:0] a);
      i_rxmon_host.rd8(a, d);
      chk("rdata", d, model(a));
   endtask
   task automatic finish_test();
      if (failures == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // ==========
   // main sequence
   initial begin
      void'($urandom(41));
      alarm_m = 0;
      foreach (pwr_m[j]) pwr_m[j] = 0;
      repeat (8) @(posedge clock_i);
      resetn_i <= 1'b1;
      @(posedge clock_i);
      chk("irq", irq, 1'h0);
      i_rxmon_host.rd8(7'h79, d);
      chk("mask", d, 8'h00);
      rdchk(7'h20);
      // measurements, second pass with a negative temperature
      for (k = 0; k < 2; k++) begin
         temp <= 16'($urandom) | {k[0], 15'h0000};
         v33 <= 16'($urandom);
         v25 <= 16'($urandom);
         repeat (210) @(posedge clock_i);
         for (i = 7'h1C; i < 7'h24; i++) rdchk(i[6:0]);
      end
      // all power channels, then index 12 which must be dropped
      for (i = 0; i < 13; i++) begin
         ch <= i[3:0];
         pw <= 16'($urandom);
         vld <= 1'b1;
         @(posedge clock_i);
         if (i < 12) pwr_m[i] = pw;
      end
      vld <= 1'b0;
      foreach (wa[j]) i_rxmon_host.wr8(wa[j], 8'hFF);
      for (i = 7'h1A; i < 7'h78; i++) rdchk(i[6:0]);
      // each alarm held across a read, then dropped and read twice
      for (k = 0; k < 3; k++) begin
         alarm_m = (k == 0) ? 'h40 : (k == 1) ? 'h08 : 'h04;
         {lo3, hi2, lo2} <= {alarm_m[6], alarm_m[3], alarm_m[2]};
         repeat (6) @(posedge clock_i);
         rdchk(7'h1A);
         {lo3, hi2, lo2} <= 3'h0;
         repeat (6) @(posedge clock_i);
         rdchk(7'h1A);
         alarm_m = 0;
         rdchk(7'h1A);
      end
      // interrupt: alarm event unmasked, cleared, then sample tick
      chk("irq", irq, 1'h0);
      i_rxmon_host.wr8(7'h79, 8'h01);
      @(posedge clock_i);
      chk("irq", irq, 1'h1);
      i_rxmon_host.wr8(7'h78, 8'h01);
      @(posedge clock_i);
      chk("irq", irq, 1'h0);
      i_rxmon_host.wr8(7'h79, 8'h02);
      // drop the stale tick status so the next tick must raise irq
      i_rxmon_host.wr8(7'h78, 8'h02);
      for (i = 0; i < 300 && irq !== 1'b1; i++) @(posedge clock_i);
      chk("irq tick", irq, 1'h1);
      i_rxmon_host.wr8(7'h79, 8'h00);
      @(posedge clock_i);
      chk("irq", irq, 1'h0);
      finish_test();
   end
endmodule // tb
